//--- byte_ram.sv
// single-port byte memory with bit write mask and registered read data
// assumes one clock; contents are not cleared by reset
`timescale 1ns/1ns
module byte_ram #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_en,
  input wire logic i_we,
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic [DW-1:0] i_wmask,
  output logic [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] rdata_q;

  always_ff @(posedge i_core_clk) begin
    if (i_en && i_we) begin
      mem[i_addr] <= (mem[i_addr] & ~i_wmask) | (i_wdata & i_wmask);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      rdata_q <= '0;
    end else if (i_en) begin
      rdata_q <= mem[i_addr];
    end
  end

  assign o_rdata = rdata_q;
endmodule // byte_ram

//--- mem_space_decoder.sv
// memory-space decoder: fetch address, vectors, internal/external data ram
// assumes the core drives one data request per cycle and sfr answers a cycle later
// What this block does
// - after reset the fetch address is program address zero
// - each interrupt vectors to a fixed slot; interrupt 10 goes to 000BH
// - vector slots eight bytes apart; unused slots stay ordinary program memory
// - sixteen-bit counter, only 32k bytes of program memory decoded
// - internal data uses 8-bit addresses; data pointer pair gives 16-bit address
// - above 7FH direct and indirect reach physically separate spaces
// - upper 128 ram bytes reached only indirectly, never by direct address
// - lowest 32 bytes are four banks of eight, status word picks bank
// - sixteen bytes above banks bit-addressable, bits 00H-7FH
// - lower 128 bytes reachable both directly and indirectly
// - internal ram is 256 bytes and holds the stack
// - separate 1k external data ram including 40 display bytes
// - external ram independent, accessed bytewise through special-function space
`timescale 1ns/1ns
module mem_space_decoder #(
  parameter int PMEM_BYTES = 32768,
  parameter int EXTERNAL_DATA_RAM_BYTES = 1024
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // fetch side
  input wire logic [15:0] i_fetch_pc,
  input wire logic i_int_take,
  input wire logic [4:0] i_int_num,
  output logic [15:0] o_fetch_addr,
  output logic [14:0] o_pmem_addr,
  output logic o_pmem_hit,
  // data side
  input wire logic i_dacc_req,
  input wire logic [2:0] i_dacc_mode,
  input wire logic i_dacc_we,
  input wire logic [7:0] i_dacc_addr,
  input wire logic [7:0] i_dacc_wdata,
  input wire logic [7:0] i_data_pointer_pair_hi,
  input wire logic [7:0] i_data_pointer_pair_lo,
  input wire logic [1:0] i_psw_bank,
  output logic [7:0] o_dacc_rdata,
  output logic o_dacc_rvalid,
  output logic o_dacc_err,
  // remaining special-function registers
  output logic o_sfr_req,
  output logic o_sfr_we,
  output logic [7:0] o_sfr_addr,
  output logic [7:0] o_sfr_wdata,
  output logic [7:0] o_sfr_wmask,
  input wire logic [7:0] i_sfr_rdata
);
  // ==========================================================
  // program fetch address
  logic [15:0] fetch_d, fetch_q;
  logic [4:0] slot;
  logic [15:0] vec_addr;

  always_comb begin
    slot = i_int_num - (mem_space_pkg::EXT_INT10_NUM - mem_space_pkg::EXT_INT10_SLOT);
    vec_addr = mem_space_pkg::VEC_FIRST
      + (16'({11'h000, slot}) << mem_space_pkg::VEC_SPACING_LOG2);
    fetch_d = i_int_take ? vec_addr : i_fetch_pc;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      fetch_q <= mem_space_pkg::RESET_VECTOR;
    end else begin
      fetch_q <= fetch_d;
    end
  end

  assign o_fetch_addr = fetch_q;
  assign o_pmem_addr = fetch_q[14:0];
  assign o_pmem_hit = (32'(fetch_q) < PMEM_BYTES);

  // ==========================================================
  // data request decode
  mem_space_pkg::acc_mode_t mode;
  logic internal_data_ram_en, external_data_ram_en, sfr_en, local_en, err;
  logic [7:0] internal_data_ram_addr, sfr_addr, wmask, wdata, local_rd;
  logic [9:0] external_data_ram_addr;
  logic [2:0] bitpos;
  logic [15:0] data_pointer_pair;
  logic [9:0] xptr_d, xptr_q;
  mem_space_pkg::rd_src_t src_d;

  always_comb begin
    mode = mem_space_pkg::acc_mode_t'(i_dacc_mode);
    data_pointer_pair = {i_data_pointer_pair_hi, i_data_pointer_pair_lo};
    internal_data_ram_en = 1'b0;
    external_data_ram_en = 1'b0;
    sfr_en = 1'b0;
    local_en = 1'b0;
    err = 1'b0;
    internal_data_ram_addr = i_dacc_addr;
    sfr_addr = i_dacc_addr;
    external_data_ram_addr = xptr_q;
    wmask = 8'hFF;
    wdata = i_dacc_wdata;
    bitpos = i_dacc_addr[2:0];
    unique case (mode)
      mem_space_pkg::ACC_DIRECT: begin
        if (i_dacc_addr <= mem_space_pkg::LOWER_TOP) begin
          internal_data_ram_en = 1'b1;
        end else if (i_dacc_addr == mem_space_pkg::SFR_XDATA) begin
          external_data_ram_en = 1'b1;
        end else if (i_dacc_addr == mem_space_pkg::SFR_XPTR_LO
                     || i_dacc_addr == mem_space_pkg::SFR_XPTR_HI) begin
          local_en = 1'b1;
        end else begin
          sfr_en = 1'b1;
        end
      end
      mem_space_pkg::ACC_INDIRECT, mem_space_pkg::ACC_STACK: begin
        internal_data_ram_en = 1'b1;
      end
      mem_space_pkg::ACC_REG: begin
        internal_data_ram_addr = {3'h0, i_psw_bank, i_dacc_addr[2:0]};
        internal_data_ram_en = 1'b1;
      end
      mem_space_pkg::ACC_BIT: begin
        wmask = 8'h01 << i_dacc_addr[2:0];
        wdata = {8{i_dacc_wdata[0]}};
        if (i_dacc_addr <= mem_space_pkg::LOWER_TOP) begin
          // base counts in eight-byte units: the bit area starts right above the banks
          internal_data_ram_addr = {mem_space_pkg::BIT_AREA_BASE, 3'h0} + {4'h0, i_dacc_addr[6:3]};
          internal_data_ram_en = 1'b1;
        end else begin
          sfr_addr = {i_dacc_addr[7:3], 3'h0};
          sfr_en = 1'b1;
        end
      end
      mem_space_pkg::ACC_MOVX: begin
        external_data_ram_addr = data_pointer_pair[9:0];
        if (32'(data_pointer_pair) < EXTERNAL_DATA_RAM_BYTES) begin
          external_data_ram_en = 1'b1;
        end else begin
          err = 1'b1;
        end
      end
      default: begin
        err = 1'b1;
      end
    endcase
    internal_data_ram_en = internal_data_ram_en & i_dacc_req;
    external_data_ram_en = external_data_ram_en & i_dacc_req;
    sfr_en = sfr_en & i_dacc_req;
    local_en = local_en & i_dacc_req;
    err = err & i_dacc_req;
    src_d = internal_data_ram_en ? mem_space_pkg::SRC_INTERNAL_DATA_RAM
          : external_data_ram_en ? mem_space_pkg::SRC_EXTERNAL_DATA_RAM
          : sfr_en ? mem_space_pkg::SRC_SFR : mem_space_pkg::SRC_LOCAL;
    local_rd = (i_dacc_addr == mem_space_pkg::SFR_XPTR_LO)
             ? xptr_q[7:0] : {6'h00, xptr_q[9:8]};
  end

  assign o_sfr_req = sfr_en;
  assign o_sfr_we = sfr_en & i_dacc_we;
  assign o_sfr_addr = sfr_addr;
  assign o_sfr_wdata = wdata;
  assign o_sfr_wmask = wmask;

  // ==========================================================
  // external ram pointer held in the special-function space
  always_comb begin
    xptr_d = xptr_q;
    if (local_en && i_dacc_we) begin
      if (i_dacc_addr == mem_space_pkg::SFR_XPTR_LO) begin
        xptr_d = {xptr_q[9:8], i_dacc_wdata};
      end else begin
        xptr_d = {i_dacc_wdata[1:0], xptr_q[7:0]};
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      xptr_q <= mem_space_pkg::XPTR_RESET;
    end else begin
      xptr_q <= xptr_d;
    end
  end

  // ==========================================================
  // memories
  logic [7:0] internal_data_ram_rd, external_data_ram_rd;

  byte_ram #(.AW(mem_space_pkg::INTERNAL_DATA_RAM_AW), .DW(8)) u_internal_data_ram (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_en(internal_data_ram_en),
    .i_we(i_dacc_we),
    .i_addr(internal_data_ram_addr),
    .i_wdata(wdata),
    .i_wmask(wmask),
    .o_rdata(internal_data_ram_rd)
  );

  byte_ram #(.AW(mem_space_pkg::EXTERNAL_DATA_RAM_AW), .DW(8)) u_external_data_ram (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_en(external_data_ram_en),
    .i_we(i_dacc_we),
    .i_addr(external_data_ram_addr),
    .i_wdata(wdata),
    .i_wmask(wmask),
    .o_rdata(external_data_ram_rd)
  );

  // ==========================================================
  // read return: stage one tracks source, stage two registers data
  mem_space_pkg::rd_src_t src_q;
  logic vld1_d, vld1_q, err1_q, bit1_q, vld2_q, err2_q;
  logic [2:0] bitpos_q;
  logic [7:0] local_q, byte_sel, rdata_d, rdata_q;

  assign vld1_d = i_dacc_req & ~i_dacc_we;

  always_comb begin
    unique case (src_q)
      mem_space_pkg::SRC_INTERNAL_DATA_RAM: byte_sel = internal_data_ram_rd;
      mem_space_pkg::SRC_EXTERNAL_DATA_RAM: byte_sel = external_data_ram_rd;
      mem_space_pkg::SRC_SFR: byte_sel = i_sfr_rdata;
      mem_space_pkg::SRC_LOCAL: byte_sel = local_q;
    endcase
    rdata_d = bit1_q ? {7'h00, byte_sel[bitpos_q]} : byte_sel;
    if (!vld1_q || err1_q) begin
      rdata_d = 8'h00;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      src_q <= mem_space_pkg::SRC_LOCAL;
      vld1_q <= 1'b0;
      err1_q <= 1'b0;
      bit1_q <= 1'b0;
      bitpos_q <= 3'h0;
      local_q <= 8'h00;
      vld2_q <= 1'b0;
      err2_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      src_q <= src_d;
      vld1_q <= vld1_d;
      err1_q <= err;
      bit1_q <= (mode == mem_space_pkg::ACC_BIT);
      bitpos_q <= bitpos;
      local_q <= local_rd;
      vld2_q <= vld1_q;
      err2_q <= err1_q;
      rdata_q <= rdata_d;
    end
  end

  assign o_dacc_rdata = rdata_q;
  assign o_dacc_rvalid = vld2_q;
  assign o_dacc_err = err2_q;
endmodule // mem_space_decoder

//--- mem_space_decoder_assertions.sv
// port-level checks of the memory-space decoder
// assumes one clock and synchronous active-low reset
`timescale 1ns/1ns
module mem_space_decoder_checker #(
  parameter int PMEM_BYTES = 32768
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic [15:0] i_fetch_pc,
  input wire logic i_int_take,
  input wire logic [4:0] i_int_num,
  input wire logic [15:0] o_fetch_addr,
  input wire logic [14:0] o_pmem_addr,
  input wire logic o_pmem_hit,
  input wire logic i_dacc_req,
  input wire logic [2:0] i_dacc_mode,
  input wire logic i_dacc_we,
  input wire logic [7:0] i_dacc_addr,
  input wire logic [7:0] i_data_pointer_pair_hi,
  input wire logic o_dacc_rvalid,
  input wire logic o_dacc_err,
  input wire logic o_sfr_req,
  input wire logic [7:0] o_sfr_addr
);
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (!i_nrst);
  // ==========================================
  // sequences
  sequence s_rd;
    i_dacc_req && !i_dacc_we && i_dacc_mode < 3'h5;
  endsequence
  sequence s_bad_ptr;
    i_dacc_req && i_dacc_mode == 3'h5 && i_data_pointer_pair_hi > 8'h03;
  endsequence
  // ==========================================
  // fetch side
  AST_RESET_FETCH: assert property (disable iff (1'b0)
    !i_nrst |=> o_fetch_addr == 16'h0000) else $error("fetch not zero after reset");
  AST_FETCH_PC: assert property (i_nrst && !i_int_take |=> o_fetch_addr == $past(i_fetch_pc))
    else $error("fetch address not pc");
  AST_VEC10: assert property (i_int_take && i_int_num == 5'h0A |=> o_fetch_addr == 16'h000B)
    else $error("interrupt ten vector wrong");
  AST_VEC_SLOT: assert property (i_int_take |=>
    o_fetch_addr == {8'h00, $past(i_int_num) - 5'h09, 3'h3}) else $error("vector slot wrong");
  AST_PMEM: assert property (o_pmem_hit == (o_fetch_addr < PMEM_BYTES)
    && o_pmem_addr == o_fetch_addr[14:0]) else $error("program decode wrong");
  // ==========================================
  // data side
  AST_INDIRECT_LOCAL: assert property (i_dacc_req && i_dacc_mode == 3'h1 |-> !o_sfr_req)
    else $error("indirect went to sfr");
  AST_DIRECT_UPPER: assert property (i_dacc_req && i_dacc_mode == 3'h0 && i_dacc_addr[7]
    && !(i_dacc_addr inside {8'hD3, 8'hDF, 8'hF9}) |-> o_sfr_req && o_sfr_addr == i_dacc_addr)
    else $error("direct upper not sfr");
  AST_LOWER_LOCAL: assert property (i_dacc_req && i_dacc_mode inside {3'h0, 3'h3}
    && !i_dacc_addr[7] |-> !o_sfr_req) else $error("lower access went to sfr");
  AST_RVALID: assert property (s_rd |-> ##2 o_dacc_rvalid && !o_dacc_err)
    else $error("read answer missing");
  AST_RVALID_CAUSE: assert property (o_dacc_rvalid |->
    $past(i_dacc_req, 2) && !$past(i_dacc_we, 2)) else $error("answer without read");
  AST_EXTERNAL_DATA_RAM_RANGE: assert property (s_bad_ptr |-> ##2 o_dacc_err)
    else $error("pointer range not flagged");
endmodule // mem_space_decoder_checker

bind mem_space_decoder mem_space_decoder_checker #(.PMEM_BYTES(PMEM_BYTES)) u_chk (
  .i_core_clk, .i_nrst, .i_fetch_pc, .i_int_take, .i_int_num, .o_fetch_addr,
  .o_pmem_addr, .o_pmem_hit, .i_dacc_req, .i_dacc_mode, .i_dacc_we, .i_dacc_addr,
  .i_data_pointer_pair_hi, .o_dacc_rvalid, .o_dacc_err, .o_sfr_req, .o_sfr_addr);

//--- mem_space_decoder_tb_top.sv
// self-checking bench of the memory-space decoder
// assumes the sfr model answers one cycle after a request
`timescale 1ns/1ns
module mem_space_decoder_tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic take = 1'b0;
  logic [4:0] inum = 5'h00;
  logic [15:0] pc = 16'h0000;
  logic req = 1'b0;
  logic [2:0] mode = 3'h0;
  logic we = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wd = 8'h00;
  logic [15:0] dp = 16'h0000;
  logic [1:0] bank = 2'h0;
  logic [15:0] fa;
  logic [14:0] pa;
  logic hit, rv, err, sreq, swe;
  logic [7:0] rd, saddr, srd, swd, swm;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  mem_space_decoder DUT (.i_core_clk(clk), .i_nrst(nrst), .i_fetch_pc(pc), .i_int_take(take),
    .i_int_num(inum), .o_fetch_addr(fa), .o_pmem_addr(pa), .o_pmem_hit(hit),
    .i_dacc_req(req), .i_dacc_mode(mode), .i_dacc_we(we), .i_dacc_addr(addr),
    .i_dacc_wdata(wd), .i_data_pointer_pair_hi(dp[15:8]), .i_data_pointer_pair_lo(dp[7:0]),
    .i_psw_bank(bank), .o_dacc_rdata(rd), .o_dacc_rvalid(rv), .o_dacc_err(err),
    .o_sfr_req(sreq), .o_sfr_we(swe), .o_sfr_addr(saddr), .o_sfr_wdata(swd), .o_sfr_wmask(swm),
    .i_sfr_rdata(srd));
  sfr_core_model P (.i_core_clk(clk), .i_sfr_req(sreq), .i_sfr_addr(saddr), .o_sfr_rdata(srd));
  // ==========================================
  // shared tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic fe(logic [15:0] p, logic t, logic [4:0] n, logic [15:0] e);
    @(posedge clk);
    pc <= p;
    take <= t;
    inum <= n;
    @(posedge clk);
    take <= 1'b0;
    #1;
    chk("fetch", fa, e);
  endtask
  // one request; returns in the cycle its answer stands
  task automatic acc(logic [2:0] m, logic w, logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    req <= 1'b1;
    mode <= m;
    we <= w;
    addr <= a;
    wd <= d;
    @(posedge clk);
    req <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic rdx(logic [2:0] m, logic [7:0] a, logic [7:0] e);
    acc(m, 1'b0, a, 8'h00);
    chk("rvalid", {15'h0000, rv}, 16'h0001);
    chk("rdata", {8'h00, rd}, {8'h00, e});
  endtask
  // ==========================================
  // scenarios
  task automatic t_fetch();
    fe(16'h7FFF, 1'b0, 5'h00, 16'h7FFF);
    chk("hit", {15'h0000, hit}, 16'h0001);
    fe(16'h8000, 1'b0, 5'h00, 16'h8000);
    chk("miss", {15'h0000, hit}, 16'h0000);
    chk("paddr", {1'b0, pa}, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      fe(16'h0100, 1'b1, 5'(10 + i), 16'h000B + 16'(8 * i));
    end
    fe(16'h000B, 1'b0, 5'h00, 16'h000B);
  endtask
  task automatic t_internal_data_ram();
    acc(3'h0, 1'b1, 8'h10, 8'h3C);
    rdx(3'h1, 8'h10, 8'h3C);
    acc(3'h1, 1'b1, 8'h90, 8'hAA);
    rdx(3'h1, 8'h90, 8'hAA);
    rdx(3'h4, 8'h90, 8'hAA);
    rdx(3'h0, 8'h90, 8'hCA);
    for (int b = 0; b < 4; b++) begin
      @(posedge clk);
      bank <= 2'(b);
      acc(3'h2, 1'b1, 8'h02, 8'(8'h50 + b));
      rdx(3'h0, 8'(8 * b + 2), 8'(8'h50 + b));
    end
    acc(3'h0, 1'b1, 8'h24, 8'h00);
    acc(3'h3, 1'b1, 8'h21, 8'h01);
    rdx(3'h0, 8'h24, 8'h02);
    rdx(3'h3, 8'h21, 8'h01);
  endtask
  task automatic t_external_data_ram();
    acc(3'h0, 1'b1, 8'hD3, 8'h28);
    acc(3'h0, 1'b1, 8'hDF, 8'h03);
    acc(3'h0, 1'b1, 8'hF9, 8'h5C);
    rdx(3'h0, 8'hF9, 8'h5C);
    rdx(3'h0, 8'hD3, 8'h28);
    rdx(3'h0, 8'hDF, 8'h03);
    @(posedge clk);
    dp <= 16'h0328;
    rdx(3'h5, 8'h00, 8'h5C);
    @(posedge clk);
    dp <= 16'h0400;
    acc(3'h5, 1'b0, 8'h00, 8'h00);
    chk("err", {15'h0000, err}, 16'h0001);
    acc(3'h6, 1'b0, 8'h00, 8'h00);
    chk("err", {15'h0000, err}, 16'h0001);
  endtask
  // byte write then bit write to the special space, both back to back
  task automatic t_sfr();
    @(posedge clk);
    req <= 1'b1;
    mode <= 3'h0;
    we <= 1'b1;
    addr <= 8'h90;
    wd <= 8'h3C;
    #1;
    chk("sfr we", {15'h0000, swe}, 16'h0001);
    chk("sfr wdata", {8'h00, swd}, 16'h003C);
    chk("sfr wmask", {8'h00, swm}, 16'h00FF);
    @(posedge clk);
    mode <= 3'h3;
    addr <= 8'h93;
    wd <= 8'h01;
    #1;
    chk("sfr bit req", {15'h0000, sreq}, 16'h0001);
    chk("sfr bit addr", {8'h00, saddr}, 16'h0090);
    chk("sfr bit wdata", {8'h00, swd}, 16'h00FF);
    chk("sfr bit wmask", {8'h00, swm}, 16'h0008);
    @(posedge clk);
    req <= 1'b0;
    we <= 1'b0;
    rdx(3'h3, 8'h93, 8'h01);
  endtask
  task automatic t_reset();
    @(posedge clk);
    nrst <= 1'b0;
    pc <= 16'h1234;
    repeat (3) @(posedge clk);
    #1;
    chk("reset", fa, 16'h0000);
    chk("reset rvalid", {15'h0000, rv}, 16'h0000);
    chk("reset hit", {15'h0000, hit}, 16'h0001);
    @(posedge clk);
    nrst <= 1'b1;
    fe(16'h0042, 1'b0, 5'h00, 16'h0042);
    rdx(3'h0, 8'hD3, 8'h00);
  endtask
  // ==========================================
  // run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    t_reset();
    t_fetch();
    t_internal_data_ram();
    t_external_data_ram();
    t_sfr();
    t_reset();
    rdx(3'h1, 8'h10, 8'h3C);
    close_out();
  end
endmodule // mem_space_decoder_tb_top

//--- mem_space_pkg.sv
// constants, enumerations and address map for the memory-space decoder
// assumes a single core clock; no other package is needed
package mem_space_pkg;

  // ==========================================================
  // program memory
  localparam int PC_W = 16;
  localparam int PMEM_AW = 15;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] VEC_FIRST = 16'h0003;
  localparam int VEC_SPACING_LOG2 = 3;
  localparam logic [4:0] EXT_INT10_NUM = 5'h0A;
  localparam logic [4:0] EXT_INT10_SLOT = 5'h01;

  // ==========================================================
  // internal data memory
  localparam int INTERNAL_DATA_RAM_AW = 8;
  localparam logic [7:0] LOWER_TOP = 8'h7F;
  localparam logic [4:0] BIT_AREA_BASE = 5'h04;
  localparam int BANK_W = 2;

  // ==========================================================
  // external data memory through the special-function space
  localparam int EXTERNAL_DATA_RAM_AW = 10;
  localparam int LCD_RAM_BYTES = 40;
  localparam logic [7:0] SFR_XPTR_LO = 8'hD3;
  localparam logic [7:0] SFR_XPTR_HI = 8'hDF;
  localparam logic [7:0] SFR_XDATA = 8'hF9;
  localparam logic [9:0] XPTR_RESET = 10'h000;

  // ==========================================================
  // data access kinds
  typedef enum logic [2:0] {
    ACC_DIRECT = 3'h0,
    ACC_INDIRECT = 3'h1,
    ACC_REG = 3'h2,
    ACC_BIT = 3'h3,
    ACC_STACK = 3'h4,
    ACC_MOVX = 3'h5
  } acc_mode_t;

  typedef enum logic [1:0] {
    SRC_INTERNAL_DATA_RAM = 2'h0,
    SRC_EXTERNAL_DATA_RAM = 2'h1,
    SRC_SFR = 2'h2,
    SRC_LOCAL = 2'h3
  } rd_src_t;

endpackage

//--- sfr_core_model.sv
// special-register file standing in for the core side
// assumes answers are due the cycle after a request
`timescale 1ns/1ns
module sfr_core_model (
  input wire logic i_core_clk,
  input wire logic i_sfr_req,
  input wire logic [7:0] i_sfr_addr,
  output logic [7:0] o_sfr_rdata
);
  logic [7:0] rdata_q = 8'h00;
  // ==========================================
  // answer
  // idle cycles toggle so stale data never looks valid
  always_ff @(posedge i_core_clk) begin
    rdata_q <= i_sfr_req ? (i_sfr_addr ^ 8'h5A) : ~rdata_q;
  end
  // read-only stand-in: there is no write input, and every answer comes from the registered reply
  assign o_sfr_rdata = rdata_q;
endmodule // sfr_core_model
